/* verilog/bax_pkg.sv */
// Package for the byte ALU slice: operation codes, widths, reset values.
// Assumes a single core clock and a synchronous active-high reset.
package bax_pkg;

  localparam int BAX_DATA_W = 8;
  localparam int BAX_ADDR_W = 7;
  localparam int BAX_NIB_W = 4;
  localparam logic [6:0] BAX_ADDR_MAX = 7'h7F;
  localparam logic [7:0] BAX_WORK_RST = 8'h00;
  localparam logic BAX_FLAG_RST = 1'b0;
  localparam logic BAX_DEST_WORK = 1'b0;
  localparam logic BAX_DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    BAX_SUB_WORK_FROM_FILE,
    BAX_XOR_WORK_WITH_FILE,
    BAX_NIBBLE_SWAP_FILE,
    BAX_XOR_LITERAL_WITH_WORK
  } bax_op_t;

  typedef enum logic [1:0] {
    BAX_IDLE,
    BAX_DONE
  } bax_state_t;

endpackage

/* verilog/bax_if.sv */
// Interface between the top and the combinational result unit.
// Assumes the top drives operands and the unit answers in the same cycle.
interface bax_if;
  import bax_pkg::*;
  bax_op_t op;
  logic [7:0] work;
  logic [7:0] operand;
  logic [7:0] result;
  logic carry;
  logic digit_carry;
  logic zero;
  logic wr_carry;
  logic wr_zero;
  modport ctrl (output op, output work, output operand,
    input result, input carry, input digit_carry, input zero, input wr_carry, input wr_zero);
  modport unit (input op, input work, input operand,
    output result, output carry, output digit_carry, output zero, output wr_carry,
    output wr_zero);
endinterface

/* verilog/bax_result.sv */
// Combinational result unit of the byte ALU slice.
// Assumes operands are stable for the cycle in which they are presented.
module bax_result
  import bax_pkg::*;
(
  bax_if.unit alu
);

  // ==========================================================
  // Subtract helpers
  function automatic logic no_borrow(input logic [7:0] a, input logic [7:0] b);
    no_borrow = (b <= a);
  endfunction

  logic [7:0] diff;
  assign diff = 8'(alu.operand - alu.work);

  // ==========================================================
  // Result select
  always_comb begin
    alu.result = 8'h00;
    alu.carry = 1'b0;
    alu.digit_carry = 1'b0;
    alu.wr_carry = 1'b0;
    alu.wr_zero = 1'b0;
    unique case (alu.op)
      BAX_SUB_WORK_FROM_FILE: begin
        alu.result = diff;
        alu.carry = no_borrow(alu.operand, alu.work);
        alu.digit_carry = no_borrow({4'h0, alu.operand[3:0]}, {4'h0, alu.work[3:0]});
        alu.wr_carry = 1'b1;
        alu.wr_zero = 1'b1;
      end
      BAX_XOR_WORK_WITH_FILE: begin
        alu.result = alu.work ^ alu.operand;
        alu.wr_zero = 1'b1;
      end
      BAX_NIBBLE_SWAP_FILE: begin
        alu.result = {alu.operand[3:0], alu.operand[7:4]};
      end
      BAX_XOR_LITERAL_WITH_WORK: begin
        alu.result = alu.work ^ alu.operand;
        alu.wr_zero = 1'b1;
      end
    endcase
  end

  assign alu.zero = (alu.result == 8'h00);

endmodule

/* verilog/bax_alu.sv */
// Top of the byte ALU slice: working register, flags, file write-back port.
// Assumes the decoder presents one instruction per valid pulse and the
// register file returns the addressed byte on file_rd_data in the same cycle.
// ==========================================================
// Summary of operation
// - Subtract computes file value minus working value, two's complement; address 0..127.
// - For file operations, destination 0 writes working register, 1 writes file.
// - Subtract carry set when work <= file; digit carry likewise on low nibbles.
// - Xor with file combines working and file, routes by destination, touches zero only.
// - Nibble swap exchanges file nibbles and leaves every flag unchanged.
// - Xor with literal combines working and literal into working register, updates zero.
module bax_alu
  import bax_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input bax_op_t instr_op,
  input wire logic [6:0] file_addr,
  input wire logic dest_sel,
  input wire logic [7:0] literal,
  input wire logic [7:0] file_rd_data,
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic [7:0] work,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic done
);

  bax_if alu ();

  bax_result u_result (
    .alu(alu)
  );

  // ==========================================================
  // Operand steering
  assign alu.op = instr_op;
  assign alu.work = work;
  assign alu.operand = (instr_op == BAX_XOR_LITERAL_WITH_WORK) ? literal : file_rd_data;

  logic to_file;
  assign to_file = (instr_op != BAX_XOR_LITERAL_WITH_WORK) && (dest_sel == BAX_DEST_FILE);

  // ==========================================================
  // Next state
  logic next_file_wr_en;
  logic [6:0] next_file_wr_addr;
  logic [7:0] next_file_wr_data;
  logic [7:0] next_work;
  logic next_carry_flag;
  logic next_digit_carry_flag;
  logic next_zero_flag;
  logic next_done;

  always_comb begin
    next_file_wr_en = 1'b0;
    next_file_wr_addr = file_wr_addr;
    next_file_wr_data = file_wr_data;
    next_work = work;
    next_carry_flag = carry_flag;
    next_digit_carry_flag = digit_carry_flag;
    next_zero_flag = zero_flag;
    next_done = 1'b0;
    if (instr_valid) begin
      next_done = 1'b1;
      if (to_file) begin
        next_file_wr_en = 1'b1;
        next_file_wr_addr = file_addr;
        next_file_wr_data = alu.result;
      end else begin
        next_work = alu.result;
      end
      if (alu.wr_carry) begin
        next_carry_flag = alu.carry;
        next_digit_carry_flag = alu.digit_carry;
      end
      if (alu.wr_zero) begin
        next_zero_flag = alu.zero;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      file_wr_en <= 1'b0;
      file_wr_addr <= 7'h00;
      file_wr_data <= 8'h00;
      work <= BAX_WORK_RST;
      carry_flag <= BAX_FLAG_RST;
      digit_carry_flag <= BAX_FLAG_RST;
      zero_flag <= BAX_FLAG_RST;
      done <= 1'b0;
    end else begin
      file_wr_en <= next_file_wr_en;
      file_wr_addr <= next_file_wr_addr;
      file_wr_data <= next_file_wr_data;
      work <= next_work;
      carry_flag <= next_carry_flag;
      digit_carry_flag <= next_digit_carry_flag;
      zero_flag <= next_zero_flag;
      done <= next_done;
    end
  end

  // ==========================================================
  // Checks
  sequence sub_issued;
    instr_valid && instr_op == BAX_SUB_WORK_FROM_FILE;
  endsequence

  sequence xor_file_issued;
    instr_valid && instr_op == BAX_XOR_WORK_WITH_FILE;
  endsequence

  sequence swap_issued;
    instr_valid && instr_op == BAX_NIBBLE_SWAP_FILE;
  endsequence

  sequence lit_issued;
    instr_valid && instr_op == BAX_XOR_LITERAL_WITH_WORK;
  endsequence

  sequence file_bound;
    instr_valid && to_file;
  endsequence

  sequence work_bound;
    instr_valid && !to_file;
  endsequence

  sequence flagged_op;
    instr_valid && instr_op != BAX_NIBBLE_SWAP_FILE;
  endsequence

  sub_result_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sub_issued and work_bound) |=> work == 8'($past(file_rd_data) - $past(work)))
    else $error("subtract result wrong");

  sub_file_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sub_issued and file_bound) |=>
      file_wr_data == 8'($past(file_rd_data) - $past(work)))
    else $error("subtract file result wrong");

  dest_file_a: assert property (@(posedge sys_clk) disable iff (reset)
    file_bound |=> file_wr_en && file_wr_addr == $past(file_addr)
      && $stable(work))
    else $error("file destination not honoured");

  dest_work_a: assert property (@(posedge sys_clk) disable iff (reset)
    work_bound |=> !file_wr_en)
    else $error("working destination wrote file");

  sub_carry_a: assert property (@(posedge sys_clk) disable iff (reset)
    sub_issued |=> carry_flag == ($past(work) <= $past(file_rd_data))
      && digit_carry_flag == (4'($past(work)) <= 4'($past(file_rd_data))))
    else $error("subtract carry wrong");

  xor_file_a: assert property (@(posedge sys_clk) disable iff (reset)
    xor_file_issued |=> $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("xor touched carry");

  xor_work_a: assert property (@(posedge sys_clk) disable iff (reset)
    (xor_file_issued and work_bound) |=>
      work == ($past(work) ^ $past(file_rd_data)))
    else $error("xor result wrong");

  xor_back_a: assert property (@(posedge sys_clk) disable iff (reset)
    (xor_file_issued and file_bound) |=>
      file_wr_data == ($past(work) ^ $past(file_rd_data)))
    else $error("xor file result wrong");

  swap_flags_a: assert property (@(posedge sys_clk) disable iff (reset)
    swap_issued |=> $stable(carry_flag)
      && $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("swap touched flags");

  swap_value_a: assert property (@(posedge sys_clk) disable iff (reset)
    (swap_issued and file_bound) |=>
      file_wr_data == {4'($past(file_rd_data)), 4'($past(file_rd_data) >> 4)})
    else $error("swap value wrong");

  swap_work_a: assert property (@(posedge sys_clk) disable iff (reset)
    (swap_issued and work_bound) |=>
      work == {4'($past(file_rd_data)), 4'($past(file_rd_data) >> 4)})
    else $error("swap working value wrong");

  xor_lit_a: assert property (@(posedge sys_clk) disable iff (reset)
    lit_issued |=> work == ($past(work) ^ $past(literal)) && !file_wr_en)
    else $error("literal xor wrong");

  lit_carry_a: assert property (@(posedge sys_clk) disable iff (reset)
    lit_issued |=> $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("literal xor touched carry");

  zero_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    (flagged_op and work_bound) |=> zero_flag == (work == 8'h00))
    else $error("zero flag wrong");

  zero_file_a: assert property (@(posedge sys_clk) disable iff (reset)
    (flagged_op and file_bound) |=> zero_flag == (file_wr_data == 8'h00))
    else $error("zero flag wrong on file result");

  retire_a: assert property (@(posedge sys_clk) disable iff (reset)
    instr_valid |=> done)
    else $error("instruction not retired");

  idle_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !instr_valid |=> !done && !file_wr_en && $stable(work)
      && $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("state changed while idle");

  reset_clear_a: assert property (@(posedge sys_clk)
    reset |=> work == BAX_WORK_RST && !file_wr_en && !done
      && carry_flag == BAX_FLAG_RST && digit_carry_flag == BAX_FLAG_RST
      && zero_flag == BAX_FLAG_RST)
    else $error("reset did not clear state");

endmodule

/* sim/bax_regfile.sv */
// Far-side model: register file read in the same cycle.
// Assumes one-cycle write enables on the core clock.
module bax_regfile (
  input wire logic sys_clk,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  assign rd_data = mem[rd_addr];
  // Bench preload, scheduled like the write port to keep one assignment kind
  task automatic preload(input logic [6:0] a, input logic [7:0] d);
    mem[a] <= d;
  endtask
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule

/* sim/testbench.sv */
// Testbench for the byte ALU slice, one task per operation.
// Assumes the package, design and register file model are compiled first.
module testbench;
  import bax_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, instr_valid, dest_sel, file_wr_en;
  logic carry_flag, digit_carry_flag, zero_flag, done;
  bax_op_t instr_op;
  logic [6:0] file_addr, file_wr_addr;
  logic [7:0] literal, file_rd_data, file_wr_data, work;
  int fails = 0;
  int samples_checked = 0;
  bax_alu dut (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_op(instr_op), .file_addr(file_addr), .dest_sel(dest_sel), .literal(literal),
    .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .work(work), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .done(done));
  bax_regfile rf (.sys_clk(sys_clk), .rd_addr(file_addr), .rd_data(file_rd_data),
    .wr_en(file_wr_en), .wr_addr(file_wr_addr), .wr_data(file_wr_data));
  // ==========================================================
  // Clock, checks and verdict
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic flags(input logic c, input logic dc, input logic z);
    chk({5'h00, carry_flag, digit_carry_flag, zero_flag}, {5'h00, c, dc, z});
  endtask
  task automatic wfile(input logic en, input logic [6:0] a, input logic [7:0] dat);
    chk({7'h00, file_wr_en}, {7'h00, en});
    if (en) begin
      chk(file_wr_data, dat);
      chk({1'b0, file_wr_addr}, {1'b0, a});
    end
  endtask
  task automatic step(input bax_op_t op, input logic [6:0] a, input logic d,
    input logic [7:0] k, input logic [7:0] f);
    @(posedge sys_clk);
    #1;
    rf.preload(a, f);
    instr_valid = 1'b1;
    instr_op = op;
    file_addr = a;
    dest_sel = d;
    literal = k;
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b0;
    chk({7'h00, done}, 8'h01);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_sub();
    step(BAX_XOR_LITERAL_WITH_WORK, 7'h00, 1'b0, 8'h01, 8'h00);
    step(BAX_SUB_WORK_FROM_FILE, 7'h03, 1'b0, 8'h00, 8'h10);
    chk(work, 8'h0F);
    flags(1'b1, 1'b0, 1'b0);
    wfile(1'b0, 7'h00, 8'h00);
    step(BAX_SUB_WORK_FROM_FILE, 7'h7F, 1'b1, 8'h00, 8'h0F);
    chk(work, 8'h0F);
    flags(1'b1, 1'b1, 1'b1);
    wfile(1'b1, 7'h7F, 8'h00);
    step(BAX_SUB_WORK_FROM_FILE, 7'h02, 1'b0, 8'h00, 8'h05);
    chk(work, 8'hF6);
    flags(1'b0, 1'b0, 1'b0);
    step(BAX_SUB_WORK_FROM_FILE, 7'h02, 1'b0, 8'h00, 8'h17);
    chk(work, 8'h21);
    flags(1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_xor();
    step(BAX_XOR_WORK_WITH_FILE, 7'h09, 1'b1, 8'h00, 8'h21);
    wfile(1'b1, 7'h09, 8'h00);
    chk(work, 8'h21);
    flags(1'b0, 1'b1, 1'b1);
    step(BAX_XOR_WORK_WITH_FILE, 7'h09, 1'b0, 8'h00, 8'hF0);
    chk(work, 8'hD1);
    flags(1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_swap();
    step(BAX_XOR_LITERAL_WITH_WORK, 7'h00, 1'b0, 8'hD1, 8'h00);
    step(BAX_NIBBLE_SWAP_FILE, 7'h05, 1'b1, 8'h00, 8'hA5);
    wfile(1'b1, 7'h05, 8'h5A);
    chk(work, 8'h00);
    flags(1'b0, 1'b1, 1'b1);
    step(BAX_NIBBLE_SWAP_FILE, 7'h06, 1'b0, 8'h00, 8'h3C);
    chk(work, 8'hC3);
    flags(1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_xor_literal_with_work();
    step(BAX_XOR_LITERAL_WITH_WORK, 7'h04, 1'b1, 8'h5A, 8'h00);
    chk(work, 8'h99);
    wfile(1'b0, 7'h00, 8'h00);
    flags(1'b0, 1'b1, 1'b0);
    step(BAX_XOR_LITERAL_WITH_WORK, 7'h04, 1'b0, 8'h99, 8'h00);
    chk(work, 8'h00);
    flags(1'b0, 1'b1, 1'b1);
  endtask
  task automatic cleared();
    chk(work, BAX_WORK_RST);
    flags(BAX_FLAG_RST, BAX_FLAG_RST, BAX_FLAG_RST);
    wfile(1'b0, 7'h00, 8'h00);
    chk({7'h00, done}, 8'h00);
  endtask
  task automatic t_b2b();
    @(posedge sys_clk);
    #1;
    rf.preload(7'h11, 8'h35);
    instr_valid = 1'b1;
    instr_op = BAX_XOR_LITERAL_WITH_WORK;
    literal = 8'h30;
    @(posedge sys_clk);
    #1;
    chk(work, 8'h30);
    instr_op = BAX_SUB_WORK_FROM_FILE;
    file_addr = 7'h11;
    dest_sel = 1'b0;
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b0;
    chk({7'h00, done}, 8'h01);
    chk(work, 8'h05);
    flags(1'b1, 1'b1, 1'b0);
  endtask
  task automatic t_reset();
    step(BAX_XOR_LITERAL_WITH_WORK, 7'h00, 1'b0, 8'h77, 8'h00);
    chk(work, 8'h72);
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    cleared();
    step(BAX_XOR_LITERAL_WITH_WORK, 7'h00, 1'b0, 8'h00, 8'h00);
    flags(1'b0, 1'b0, 1'b1);
  endtask
  initial begin
    #50000;
    fails++;
    results();
  end
  initial begin
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_op = BAX_SUB_WORK_FROM_FILE;
    file_addr = 7'h00;
    dest_sel = 1'b0;
    literal = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    cleared();
    t_sub();
    t_xor();
    t_swap();
    t_xor_literal_with_work();
    t_b2b();
    t_reset();
    results();
  end
endmodule
